// ---- bench/local_bus_model.sv ----
`timescale 1ns/1ns
// Memory and port devices on the local bus
module local_bus_model
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        push_valid,
  input  wire logic [15:0] push_data,
  input  wire logic        io_valid,
  input  wire logic [15:0] io_port,
  output logic      [15:0] stack_top,
  output logic      [15:0] dev_port
);
  // Stack memory keeps the last saved word; port devices avoid the reserved span
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stack_top <= 16'h0000;
      dev_port  <= 16'h0000;
    end
    else
    begin
      if (push_valid)
        stack_top <= push_data;
      if (io_valid && !(io_port >= 16'h00F8 && io_port <= 16'h00FF))
        dev_port <= io_port;
    end
  end
endmodule

// ---- bench/operand_address_generation_assertions.sv ----
`timescale 1ns/1ns
// Port-level checks of operand, offset, port, save and branch timing
module opaddr_checker
  import opaddr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        req,
  input wire logic        op_is_mem,
  input wire logic        op_byte,
  input wire addr_mode_e  mode,
  input wire logic        disp_wide,
  input wire logic [15:0] disp_in,
  input wire logic        seg_override,
  input wire seg_sel_e    seg_override_sel,
  input wire logic [15:0] gen_regs [0:7],
  input wire logic [15:0] seg_regs [0:3],
  input wire logic [15:0] instr_ptr,
  input wire logic [15:0] status_word,
  input wire logic        io_req,
  input wire logic        io_use_ptr,
  input wire logic [7:0]  io_imm_port,
  input wire logic        int_entry,
  input wire logic        jcz_req,
  input wire logic        op_valid,
  input wire logic [15:0] op_value,
  input wire logic        mem_valid,
  input wire logic [15:0] mem_seg,
  input wire logic [15:0] mem_offset,
  input wire logic [19:0] mem_phys,
  input wire logic        io_valid,
  input wire logic [15:0] io_port,
  input wire logic        push_valid,
  input wire logic [15:0] push_data,
  input wire logic        push_busy,
  input wire logic        jcz_valid,
  input wire logic        jcz_taken
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_reg_latency: assert property (req && !op_is_mem |=> op_valid)
    else $error("register operand late");
  a_byte_fill: assert property (req && !op_is_mem && op_byte |=> op_value[15:8] == 8'h00)
    else $error("byte operand upper byte set");
  a_mem_latency: assert property (req && op_is_mem |=> mem_valid)
    else $error("offset late");
  a_phys_sum: assert property (mem_valid |-> mem_phys == {mem_seg, 4'h0} + {4'h0, mem_offset})
    else $error("address pair mismatch");
  a_direct_disp: assert property (req && op_is_mem && mode == MODE_DIRECT && disp_wide
    |=> mem_offset == $past(disp_in))
    else $error("direct offset wrong");
  a_seg_override: assert property (req && op_is_mem && seg_override
    |=> mem_seg == $past(seg_regs[seg_override_sel]))
    else $error("override segment wrong");
  a_port_zext: assert property (io_req && !io_use_ptr
    |=> io_valid && io_port == {8'h00, $past(io_imm_port)})
    else $error("short port not zero extended");
  a_push_order: assert property (int_entry && !push_busy |=> push_busy
    ##1 push_valid && push_data == $past(status_word, 2)
    ##1 push_valid && push_data == $past(seg_regs[1], 3)
    ##1 push_valid && push_data == $past(instr_ptr, 4) && !push_busy
    ##1 !push_valid)
    else $error("save sequence wrong");
  a_count_zero: assert property (jcz_req
    |=> jcz_valid && jcz_taken == ($past(gen_regs[1]) == 16'h0000))
    else $error("count branch wrong");
  c_bidx_disp: cover property (req && op_is_mem && mode == MODE_BIDX_DSP);
  c_jump_taken: cover property (jcz_valid && jcz_taken);
  c_int_refused: cover property (int_entry && push_busy);
endmodule

bind operand_address_generation opaddr_checker chk (.clk, .rst_n, .req, .op_is_mem, .op_byte,
  .mode, .disp_wide, .disp_in, .seg_override, .seg_override_sel, .gen_regs, .seg_regs,
  .instr_ptr, .status_word, .io_req, .io_use_ptr, .io_imm_port, .int_entry, .jcz_req,
  .op_valid, .op_value, .mem_valid, .mem_seg, .mem_offset, .mem_phys, .io_valid, .io_port,
  .push_valid, .push_data, .push_busy, .jcz_valid, .jcz_taken);

// ---- bench/tb_operand_address_generation.sv ----
`timescale 1ns/1ns
module tb_operand_address_generation
  import opaddr_pkg::*;
;
  logic        clk, rst_n, req, op_is_mem, op_is_imm, op_byte, base_is_bp, index_is_di;
  logic        disp_wide, seg_override, string_dest, stack_ref, code_ref;
  logic        io_req, io_use_ptr, int_entry, jcz_req, op_valid, op_neg, mem_valid;
  logic        io_valid, io_reserved, push_valid, push_busy, jcz_valid, jcz_taken;
  logic [2:0]  reg_sel;
  logic [7:0]  io_imm_port;
  logic [15:0] imm_val, disp_in, instr_ptr, status_word, op_value, mem_seg, mem_offset;
  logic [15:0] io_port, push_data;
  logic [15:0] gen_regs [0:7];
  logic [15:0] seg_regs [0:3];
  logic [19:0] mem_phys;
  addr_mode_e  mode;
  ptr_sel_e    ptr_sel;
  seg_sel_e    seg_override_sel;
  logic [31:0] seed;
  logic [35:0] exp_q [$];   // Expected results, kind in the top nibble
  int          failures, samples_checked;

  operand_address_generation dut (.clk, .rst_n, .req, .op_is_mem, .op_is_imm, .op_byte,
    .reg_sel, .imm_val, .mode, .ptr_sel, .base_is_bp, .index_is_di, .disp_wide, .disp_in,
    .seg_override, .seg_override_sel, .string_dest, .stack_ref, .code_ref, .gen_regs,
    .seg_regs, .instr_ptr, .status_word, .io_req, .io_use_ptr, .io_imm_port, .int_entry,
    .jcz_req, .op_valid, .op_value, .op_neg, .mem_valid, .mem_seg, .mem_offset, .mem_phys,
    .io_valid, .io_port, .io_reserved, .push_valid, .push_data, .push_busy, .jcz_valid,
    .jcz_taken);
  local_bus_model bus (.clk, .rst_n, .push_valid, .push_data, .io_valid, .io_port,
    .stack_top(), .dev_port());

  // Clock of 100 ns period
  always #50 clk = ~clk;

  // Fixed-seed xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Short displacement widened by its sign bit
  function automatic logic [15:0] sx(input logic w, input logic [15:0] d);
    return w ? d : {{8{d[7]}}, d[7:0]};
  endfunction

  // Oldest expectation against the result now on the outputs
  task automatic check(input logic [35:0] got);
    logic [35:0] e;
    samples_checked++;
    e = (exp_q.size() == 0) ? 36'h0 : exp_q.pop_front();
    if (got !== e)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, e);
    end
  endtask

  // Results are settled by the falling edge
  always @(negedge clk)
  begin
    if (op_valid) check({4'h1, 15'h0, op_neg, op_value});
    if (mem_valid) check({4'h2, mem_seg, mem_offset});
    if (io_valid) check({4'h3, 15'h0, io_reserved, io_port});
    if (push_valid) check({4'h4, 16'h0, push_data});
    if (jcz_valid) check({4'h5, 31'h0, jcz_taken});
  end

  // Register or immediate operand request
  task automatic reg_op(input logic imm, input logic by, input logic [2:0] r);
    logic [15:0] v, e;
    v = 16'(rnd());
    e = gen_regs[by ? {1'b0, r[1:0]} : r];
    if (by)
      e = {8'h00, r[2] ? e[15:8] : e[7:0]};
    if (imm)
      e = by ? {8'h00, v[7:0]} : v;
    req <= 1;
    op_is_mem <= 0;
    op_is_imm <= imm;
    op_byte <= by;
    reg_sel <= r;
    imm_val <= v;
    exp_q.push_back({4'h1, 15'h0, by ? e[7] : e[15], e});
    @(posedge clk);
  endtask

  // Memory operand request with random base, index and displacement; pointer choice from the caller
  task automatic mem_op(input addr_mode_e m, input ptr_sel_e p);
    logic [31:0] r;
    logic [15:0] b, x, o, s;
    logic        bp, ubp, udi;
    r = rnd();
    bp = r[16];
    b = bp ? gen_regs[5] : gen_regs[3];
    x = r[17] ? gen_regs[7] : gen_regs[6];
    case (m)
      MODE_DIRECT: o = sx(r[18], r[15:0]);
      MODE_REG_IND: o = p[1] ? (p[0] ? gen_regs[5] : gen_regs[3]) : gen_regs[6 + p[0]];
      MODE_BASED: o = b + sx(r[18], r[15:0]);
      MODE_INDEXED: o = x + sx(r[18], r[15:0]);
      MODE_BIDX: o = b + x;
      default: o = b + x + sx(r[18], r[15:0]);
    endcase
    ubp = (m == MODE_REG_IND) ? (p == PTR_BASE_PTR)
                              : (bp && m != MODE_DIRECT && m != MODE_INDEXED);
    udi = (m == MODE_REG_IND) ? (p == PTR_DEST_IDX)
                              : (r[17] && m != MODE_DIRECT && m != MODE_BASED);
    if (r[19] && r[27])
      s = seg_regs[r[21:20]];
    else if (r[22] && r[28])
      s = seg_regs[1];
    else if (r[23] || ubp)
      s = seg_regs[2];
    else if (r[24] && udi)
      s = seg_regs[0];
    else
      s = seg_regs[3];
    req <= 1;
    op_is_mem <= 1;
    mode <= m;
    ptr_sel <= p;
    base_is_bp <= bp;
    index_is_di <= r[17];
    disp_wide <= r[18];
    disp_in <= r[15:0];
    seg_override <= r[19] && r[27];
    seg_override_sel <= seg_sel_e'(r[21:20]);
    code_ref <= r[22] && r[28];
    stack_ref <= r[23];
    string_dest <= r[24];
    exp_q.push_back({4'h2, s, o});
    @(posedge clk);
  endtask

  // Port address request
  task automatic io_op(input logic p, input logic [7:0] n);
    logic [15:0] e;
    e = p ? gen_regs[2] : {8'h00, n};
    io_req <= 1;
    io_use_ptr <= p;
    io_imm_port <= n;
    exp_q.push_back({4'h3, 15'h0, e >= 16'h00F8 && e <= 16'h00FF, e});
    @(posedge clk);
  endtask

  // Count-zero branch decision
  task automatic jcz_op(input logic [15:0] c);
    gen_regs[1] <= c;
    jcz_req <= 1;
    exp_q.push_back({4'h5, 31'h0, c == 16'h0000});
    @(posedge clk);
  endtask

  // Drop all strobes, wait for every result, then let stray ones show
  task automatic drain(input string name);
    int n;
    req <= 0;
    io_req <= 0;
    jcz_req <= 0;
    int_entry <= 0;
    n = 0;
    while (exp_q.size() != 0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    repeat (6) @(posedge clk);
    if (exp_q.size() != 0)
    begin
      failures++;
      $display("[ERR] %0t results missing", $time);
      give_verdict();
    end
    else
      $display("test %s done", name);
  endtask

  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    seed = 32'hF14D9B5B;
    {clk, rst_n, req, op_is_mem, op_is_imm, op_byte, base_is_bp, index_is_di} = 8'h00;
    {disp_wide, seg_override, string_dest, stack_ref, code_ref} = 5'h00;
    {io_req, io_use_ptr, int_entry, jcz_req, reg_sel, io_imm_port} = 15'h0000;
    {imm_val, disp_in, instr_ptr, status_word} = {rnd(), rnd()};
    mode = MODE_DIRECT;
    ptr_sel = PTR_SRC_IDX;
    seg_override_sel = SEG_CODE;
    failures = 0;
    samples_checked = 0;
    for (int i = 0; i < 8; i++) gen_regs[i] = 16'(rnd());
    for (int i = 0; i < 4; i++) seg_regs[i] = 16'(rnd());
    gen_regs[2] = 16'h01F8;
    repeat (5) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    for (int i = 0; i < 16; i++) reg_op(0, i[3], i[2:0]);
    reg_op(1, 0, 3'h0);
    reg_op(1, 1, 3'h4);
    drain("operands");
    for (int i = 0; i < 48; i++)
      mem_op(addr_mode_e'(i % 6), ptr_sel_e'(i / 12));
    drain("offsets");
    io_op(0, 8'hF7);
    io_op(0, 8'hF8);
    io_op(0, 8'hFF);
    io_op(1, 8'hF8);
    drain("ports");
    int_entry <= 1;
    exp_q.push_back({4'h4, 16'h0, status_word});
    exp_q.push_back({4'h4, 16'h0, seg_regs[1]});
    exp_q.push_back({4'h4, 16'h0, instr_ptr});
    @(posedge clk);
    status_word <= ~status_word; // Later changes must stay off the stack
    instr_ptr <= ~instr_ptr;
    seg_regs[1] <= ~seg_regs[1];
    @(posedge clk);
    drain("save");
    jcz_op(16'h0000);
    jcz_op(16'h0001);
    jcz_op(16'h8000);
    drain("branch");
    give_verdict();
  end
endmodule

// ---- hw/offset_adder.sv ----
`timescale 1ns/1ns
`include "opaddr_params.svh"
// Three-term effective offset adder with carry dropped
module offset_adder
  import opaddr_pkg::*;
#(
  parameter int W = `WORD_W
)
(
  input  wire logic [W-1:0] disp,      // Displacement, already widened
  input  wire logic [W-1:0] base_val,  // Base term or zero
  input  wire logic [W-1:0] index_val, // Index term or zero
  output      logic [W-1:0] sum        // Offset modulo 2^W
);
  // Sum kept at W bits so any carry out falls away
  assign sum = W'(disp + base_val + index_val);
endmodule

// ---- hw/opaddr_params.svh ----
`ifndef OPADDR_PARAMS_SVH
`define OPADDR_PARAMS_SVH
`define WORD_W        16
`define RSV_PORT_LO   16'h00F8
`define RSV_PORT_HI   16'h00FF
`define PUSH_WORDS    3
`define STRING_MAX    17'h10000
`endif

// ---- hw/opaddr_pkg.sv ----
package opaddr_pkg;
  // Memory addressing modes
  typedef enum logic [2:0] {
    MODE_DIRECT   = 3'b000,
    MODE_REG_IND  = 3'b001,
    MODE_BASED    = 3'b010,
    MODE_INDEXED  = 3'b011,
    MODE_BIDX     = 3'b100,
    MODE_BIDX_DSP = 3'b101
  } addr_mode_e;
  // Pointer register choice for register indirect
  typedef enum logic [1:0] {
    PTR_SRC_IDX  = 2'b00,
    PTR_DEST_IDX = 2'b01,
    PTR_BASE_B   = 2'b10,
    PTR_BASE_PTR = 2'b11
  } ptr_sel_e;
  // Segment registers
  typedef enum logic [1:0] {
    SEG_EXTRA = 2'b00,
    SEG_CODE  = 2'b01,
    SEG_STACK = 2'b10,
    SEG_DATA  = 2'b11
  } seg_sel_e;
  // Interrupt push sequencer states
  typedef enum logic [1:0] {
    PUSH_IDLE   = 2'b00,
    PUSH_STATUS = 2'b01,
    PUSH_CODE   = 2'b10,
    PUSH_IPTR   = 2'b11
  } push_state_e;
endpackage

// ---- hw/operand_address_generation.sv ----
`timescale 1ns/1ns
`include "opaddr_params.svh"
// Operand and address former of the core
// Forms operands, memory offsets, port addresses, interrupt saves and the
// count-zero decision; every result leaves through a register
module operand_address_generation
  import opaddr_pkg::*;
#(
  parameter int W = `WORD_W
)
(
  input  wire logic          clk,              // Processor clock
  input  wire logic          rst_n,            // Asynchronous reset, active low
  // Operand request
  input  wire logic          req,              // Start of one operand calculation
  input  wire logic          op_is_mem,        // Memory operand, else register/immediate
  input  wire logic          op_is_imm,        // Immediate operand
  input  wire logic          op_byte,          // Byte operand size
  input  wire logic [2:0]    reg_sel,          // General register number
  input  wire logic [W-1:0]  imm_val,          // Immediate operand
  input  wire addr_mode_e    mode,             // Memory addressing mode
  input  wire ptr_sel_e      ptr_sel,          // Register indirect pointer
  input  wire logic          base_is_bp,       // Base is base_pointer_reg
  input  wire logic          index_is_di,      // Index is dest_index_reg
  input  wire logic          disp_wide,        // Displacement is 16 bits
  input  wire logic [W-1:0]  disp_in,          // Raw displacement
  input  wire logic          seg_override,     // Override prefix present
  input  wire seg_sel_e      seg_override_sel, // Overriding segment
  input  wire logic          string_dest,      // String destination reference
  input  wire logic          stack_ref,        // Push or pop reference
  input  wire logic          code_ref,         // Prefetch or immediate fetch
  // Register file views
  input  wire logic [W-1:0]  gen_regs [0:7],   // General registers, word numbering
  input  wire logic [W-1:0]  seg_regs [0:3],   // Extra, code, stack, data segments
  input  wire logic [W-1:0]  instr_ptr,        // Current instruction pointer
  input  wire logic [W-1:0]  status_word,      // Current status word
  // Port request
  input  wire logic          io_req,           // Port access request
  input  wire logic          io_use_ptr,       // Port from port_pointer_reg
  input  wire logic [7:0]    io_imm_port,      // Port from instruction
  // Interrupt entry and count jump
  input  wire logic          int_entry,        // Begin interrupt save
  input  wire logic          jcz_req,          // jump_if_count_zero evaluation
  // Results
  output logic               op_valid,         // Result below is fresh
  output logic [W-1:0]       op_value,         // Register or immediate operand
  output logic               op_neg,           // Signed operand is negative
  output logic               mem_valid,        // Memory address fresh
  output logic [W-1:0]       mem_seg,          // Segment base
  output logic [W-1:0]       mem_offset,       // Effective offset
  output logic [W+3:0]       mem_phys,         // Segment shifted plus offset
  output logic               io_valid,         // Port address fresh
  output logic [W-1:0]       io_port,          // Full port address
  output logic               io_reserved,      // Port in reserved range
  output logic               push_valid,       // Stack word write strobe
  output logic [W-1:0]       push_data,        // Word being saved
  output logic               push_busy,        // Save sequence running
  output logic               jcz_valid,        // Branch decision fresh
  output logic               jcz_taken         // Branch taken
);
  // Slots of the general register view
  localparam int RIDX_COUNT    = 1; // count_reg
  localparam int RIDX_PORT     = 2; // port_pointer_reg
  localparam int RIDX_BASE_B   = 3; // base_reg_b
  localparam int RIDX_BASE_PTR = 5; // base_pointer_reg
  localparam int RIDX_SRC      = 6; // Source index
  localparam int RIDX_DEST     = 7; // dest_index_reg

  // Register and immediate operand selection
  // Byte numbers 0-3 name the low halves of word registers 0-3 and byte
  // numbers 4-7 their high halves
  wire [W-1:0] reg_word  = gen_regs[reg_sel];                    // 16-bit register
  wire [7:0]   reg_byte  = reg_sel[2] ? gen_regs[reg_sel[1:0]][15:8]
                                      : gen_regs[reg_sel[1:0]][7:0]; // AL..BH
  wire [W-1:0] reg_opnd  = op_byte ? {8'h00, reg_byte} : reg_word;
  wire [W-1:0] imm_opnd  = op_byte ? {8'h00, imm_val[7:0]} : imm_val;
  wire [W-1:0] opnd_nxt  = op_is_imm ? imm_opnd : reg_opnd;
  // Sign taken from the operand's top bit, two's complement view
  wire         neg_nxt   = op_byte ? opnd_nxt[7] : opnd_nxt[15];

  // Displacement widening
  // A short displacement is a signed byte, so it can reach backwards too
  wire [W-1:0] disp_ext  = disp_wide ? disp_in
                                     : {{8{disp_in[7]}}, disp_in[7:0]};

  // Term selection per mode
  // Base and index choices for the modes that name them directly
  wire [W-1:0] base_reg  = base_is_bp ? gen_regs[RIDX_BASE_PTR] : gen_regs[RIDX_BASE_B];
  wire [W-1:0] index_reg = index_is_di ? gen_regs[RIDX_DEST] : gen_regs[RIDX_SRC];
  logic [W-1:0] ind_reg;
  logic [W-1:0] t_disp;
  logic [W-1:0] t_base;
  logic [W-1:0] t_index;
  logic         uses_bp;
  logic         uses_di;

  // Register indirect pointer choice
  always_comb
  begin
    unique case (ptr_sel)
      PTR_SRC_IDX:  ind_reg = gen_regs[RIDX_SRC];
      PTR_DEST_IDX: ind_reg = gen_regs[RIDX_DEST];
      PTR_BASE_B:   ind_reg = gen_regs[RIDX_BASE_B];
      PTR_BASE_PTR: ind_reg = gen_regs[RIDX_BASE_PTR];
    endcase
  end

  // Elements a mode leaves out stay zero, so one adder serves all six modes
  // Mode decides which of the three elements join the sum
  always_comb
  begin
    t_disp  = '0;
    t_base  = '0;
    t_index = '0;
    uses_bp = 1'b0;
    uses_di = 1'b0;
    unique case (mode)
      MODE_DIRECT:
      begin
        t_disp = disp_ext;
      end
      MODE_REG_IND:
      begin
        t_base  = ind_reg;
        uses_bp = (ptr_sel == PTR_BASE_PTR);
        uses_di = (ptr_sel == PTR_DEST_IDX);
      end
      MODE_BASED:
      begin
        t_disp  = disp_ext;
        t_base  = base_reg;
        uses_bp = base_is_bp;
      end
      MODE_INDEXED:
      begin
        t_disp  = disp_ext;
        t_index = index_reg;
        uses_di = index_is_di;
      end
      MODE_BIDX:
      begin
        t_base  = base_reg;
        t_index = index_reg;
        uses_bp = base_is_bp;
        uses_di = index_is_di;
      end
      MODE_BIDX_DSP:
      begin
        t_disp  = disp_ext;
        t_base  = base_reg;
        t_index = index_reg;
        uses_bp = base_is_bp;
        uses_di = index_is_di;
      end
      default:
      begin
        t_disp = disp_ext; // Unused codes fall back to direct
      end
    endcase
  end

  // Effective offset
  // Carry past the top bit is lost, so offsets and strings wrap within the segment
  wire [W-1:0] eff_offset;
  offset_adder #(
    .W (W)
  ) u_adder (
    .disp      (t_disp),
    .base_val  (t_base),
    .index_val (t_index),
    .sum       (eff_offset)
  );

  // Implicit segment choice, override wins
  // Fetches go to the code segment, stack and base-pointer references to the
  // stack segment, string destinations through the index to the extra one
  wire seg_sel_e seg_implicit = code_ref                  ? SEG_CODE  :
                                (stack_ref || uses_bp)    ? SEG_STACK :
                                (string_dest && uses_di)  ? SEG_EXTRA :
                                                            SEG_DATA;
  wire seg_sel_e seg_pick     = seg_override ? seg_override_sel : seg_implicit;
  wire [W-1:0]   seg_base     = seg_regs[seg_pick];
  // Physical address from the two 16-bit parts
  wire [W+3:0]   phys_nxt     = (W+4)'({seg_base, 4'h0} + {4'h0, eff_offset});

  // Port address formation over the full 64K port space
  // The reserved span is only flagged; the access still goes out, and keeping
  // user devices clear of it is left to the system's port decoding
  wire [W-1:0] port_nxt = io_use_ptr ? gen_regs[RIDX_PORT]
                                     : {8'h00, io_imm_port};
  wire         rsv_nxt  = (port_nxt >= `RSV_PORT_LO) && (port_nxt <= `RSV_PORT_HI);

  // Count-zero branch condition
  // Only an exact zero branches; any other count falls through
  wire         cz_nxt   = (gen_regs[RIDX_COUNT] == 16'h0000);

  // Result strobes: each request shows its answer one cycle later
  // Strobes drop back one cycle after their request does; the data beside them holds
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_valid  <= 1'b0;
      mem_valid <= 1'b0;
      io_valid  <= 1'b0;
      jcz_valid <= 1'b0;
    end
    else
    begin
      op_valid  <= req && !op_is_mem;
      mem_valid <= req && op_is_mem;
      io_valid  <= io_req;
      jcz_valid <= jcz_req;
    end
  end

  // Register or immediate operand, held until the next register or immediate request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_value <= '0;
      op_neg   <= 1'b0;
    end
    else if (req && !op_is_mem)
    begin
      op_value <= opnd_nxt;
      op_neg   <= neg_nxt;
    end
  end

  // Memory reference: segment and offset travel as one 32-bit pair
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_seg    <= '0;
      mem_offset <= '0;
      mem_phys   <= '0;
    end
    else if (req && op_is_mem)
    begin
      mem_seg    <= seg_base;
      mem_offset <= eff_offset;
      mem_phys   <= phys_nxt;
    end
  end

  // Port address and its reserved-range flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_port     <= '0;
      io_reserved <= 1'b0;
    end
    else if (io_req)
    begin
      io_port     <= port_nxt;
      io_reserved <= rsv_nxt;
    end
  end

  // Count-zero branch decision, held until the next evaluation
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      jcz_taken <= 1'b0;
    else if (jcz_req)
      jcz_taken <= cz_nxt;
  end

  // Interrupt save: status, then code segment, then instruction pointer
  // All three words are captured on the entry edge, so the stack sees the
  // state of the moment the interrupt was taken even if the core moves on
  push_state_e  push_r;    // Save sequencer state
  push_state_e  push_nxt;  // Its next value
  logic [W-1:0] save_sw_r; // Status word at entry
  logic [W-1:0] save_cs_r; // Code segment at entry
  logic [W-1:0] save_ip_r; // Instruction pointer at entry
  wire          take_int = (push_r == PUSH_IDLE) && int_entry; // Entry while busy is dropped

  // Next state of the save sequencer
  always_comb
  begin
    unique case (push_r)
      PUSH_IDLE:   push_nxt = take_int ? PUSH_STATUS : PUSH_IDLE;
      PUSH_STATUS: push_nxt = PUSH_CODE;
      PUSH_CODE:   push_nxt = PUSH_IPTR;
      PUSH_IPTR:   push_nxt = PUSH_IDLE;
    endcase
  end

  // Sequencer state and busy flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      push_r    <= PUSH_IDLE;
      push_busy <= 1'b0;
    end
    else
    begin
      push_r    <= push_nxt;
      push_busy <= (push_nxt != PUSH_IDLE);
    end
  end

  // Snapshot of the words to save, taken only on an accepted entry
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      save_sw_r <= '0;
      save_cs_r <= '0;
      save_ip_r <= '0;
    end
    else if (take_int)
    begin
      save_sw_r <= status_word;
      save_cs_r <= seg_regs[SEG_CODE];
      save_ip_r <= instr_ptr;
    end
  end

  // One stack word per cycle while the sequencer walks its three states
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      push_valid <= 1'b0;
      push_data  <= '0;
    end
    else
    begin
      push_valid <= (push_r != PUSH_IDLE);
      unique case (push_r)
        PUSH_IDLE:   push_data <= push_data;
        PUSH_STATUS: push_data <= save_sw_r;
        PUSH_CODE:   push_data <= save_cs_r;
        PUSH_IPTR:   push_data <= save_ip_r;
      endcase
    end
  end
endmodule
